/* File: fmirq_monitor.sv */
// Fault supervision: status flags, shutdowns, host resets and the fault interrupt.
// Assumes the serial register interface reads the status and source outputs and
// strobes the control writes and the interrupt acknowledge for one cycle each.
`timescale 1ns/1ps
module fmirq_monitor #(
  parameter int unsigned TRANSMIT_DOMINANT_FLAG_CYCLES = fmirq_pkg::TRANSMIT_DOMINANT_FLAG_CYCLES,
  parameter int unsigned NREQ_CYCLES = fmirq_pkg::NREQ_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Device state and pins
  input wire fmirq_pkg::fmirq_mode_e mode,
  input wire logic txd,
  input wire fmirq_pkg::fmirq_fault_s fault_raw,
  // Watchdog engine events
  input wire logic wd_expired,
  input wire logic wd_clear_closed,
  // Host writes and configuration
  input wire logic high_side_control_write,
  input wire logic low_side_control_write,
  input wire logic high_voltage_shutdown_enable,
  input wire fmirq_pkg::fmirq_mask_s irq_mask,
  input wire logic irq_ack,
  // Status and interrupt
  output fmirq_pkg::fmirq_status_s status,
  output logic [3:0] interrupt_source,
  output logic irq_b,
  // Actions
  output logic lin_tx_enable,
  output logic high_side_enable,
  output logic low_side_enable,
  output logic regulator_enable,
  output logic host_reset_req,
  output logic go_sleep
);

  // ----------------------------------------------------------------
  // Synchronised faults and mode decode
  // ----------------------------------------------------------------
  fmirq_pkg::fmirq_fault_s flt;
  fmirq_pkg::fmirq_fault_s flt_prev;
  logic transmit_dominant_flag_expired;
  logic nreq_expired;
  logic in_run_mode;
  logic in_low_power;
  logic irq_allowed;
  logic hv_shutdown;

  fmirq_sync #(
    .WIDTH($bits(fmirq_pkg::fmirq_fault_s))
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .async_in(fault_raw),
    .sync_out(flt)
  );

  assign in_run_mode = (mode == fmirq_pkg::MODE_NORMAL) || (mode == fmirq_pkg::MODE_NORMAL_REQUEST);
  assign in_low_power = (mode == fmirq_pkg::MODE_STOP) || (mode == fmirq_pkg::MODE_SLEEP);
  assign irq_allowed = in_run_mode || (mode == fmirq_pkg::MODE_STOP);
  assign hv_shutdown = flt.supply_overvolt && high_voltage_shutdown_enable
                       && (mode == fmirq_pkg::MODE_NORMAL);

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  // The dominant timer only runs while the transmitter is still on, so a
  // latched shutdown cannot re-fire until TXD has gone high again.
  fmirq_timer #(
    .LIMIT(TRANSMIT_DOMINANT_FLAG_CYCLES)
  ) u_transmit_dominant_flag (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .run(in_run_mode && !txd && lin_tx_enable),
    .expired(transmit_dominant_flag_expired)
  );

  fmirq_timer #(
    .LIMIT(NREQ_CYCLES)
  ) u_nreq (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .run(mode == fmirq_pkg::MODE_NORMAL_REQUEST),
    .expired(nreq_expired)
  );

  // ----------------------------------------------------------------
  // Shutdown latches
  // ----------------------------------------------------------------
  logic hs_thermal_off;
  logic ls_thermal_off;
  logic hs_hv_off;
  logic ls_hv_off;
  logic tx_dominant_off;
  logic reg_shut;
  logic next_hs_thermal_off;
  logic next_ls_thermal_off;
  logic next_hs_hv_off;
  logic next_ls_hv_off;
  logic next_tx_dominant_off;
  logic next_reg_shut;

  always_comb begin
    next_hs_thermal_off = hs_thermal_off;
    next_ls_thermal_off = ls_thermal_off;
    next_hs_hv_off = hs_hv_off;
    next_ls_hv_off = ls_hv_off;
    next_tx_dominant_off = tx_dominant_off;
    next_reg_shut = reg_shut;
    if (flt.hs_overtemp) begin
      next_hs_thermal_off = 1'b1;
    end else if (high_side_control_write) begin
      next_hs_thermal_off = 1'b0;
    end
    if (flt.ls_overtemp) begin
      next_ls_thermal_off = 1'b1;
    end else if (low_side_control_write) begin
      next_ls_thermal_off = 1'b0;
    end
    if (hv_shutdown) begin
      next_hs_hv_off = 1'b1;
      next_ls_hv_off = 1'b1;
    end else begin
      if (high_side_control_write && !flt.supply_overvolt) begin
        next_hs_hv_off = 1'b0;
      end
      if (low_side_control_write && !flt.supply_overvolt) begin
        next_ls_hv_off = 1'b0;
      end
    end
    if (transmit_dominant_flag_expired) begin
      next_tx_dominant_off = 1'b1;
    end else if (txd) begin
      next_tx_dominant_off = 1'b0;
    end
    // The regulator stays down until the mode machine has reached Sleep.
    if (flt.reg_overtemp && !in_low_power) begin
      next_reg_shut = 1'b1;
    end else if (mode == fmirq_pkg::MODE_SLEEP) begin
      next_reg_shut = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hs_thermal_off <= 1'b0;
      ls_thermal_off <= 1'b0;
      hs_hv_off <= 1'b0;
      ls_hv_off <= 1'b0;
      tx_dominant_off <= 1'b0;
      reg_shut <= 1'b0;
    end else begin
      hs_thermal_off <= next_hs_thermal_off;
      ls_thermal_off <= next_ls_thermal_off;
      hs_hv_off <= next_hs_hv_off;
      ls_hv_off <= next_ls_hv_off;
      tx_dominant_off <= next_tx_dominant_off;
      reg_shut <= next_reg_shut;
    end
  end

  // ----------------------------------------------------------------
  // Actions and status flags
  // ----------------------------------------------------------------
  fmirq_pkg::fmirq_status_s next_status;
  logic next_lin_tx_enable;
  logic next_high_side_enable;
  logic next_low_side_enable;
  logic next_regulator_enable;
  logic next_host_reset_req;
  logic next_go_sleep;

  always_comb begin
    next_status = '{default: fmirq_pkg::FLAGS_RESET};
    next_status.supply_status[fmirq_pkg::SUP_BATTERY_FAIL_BIT] = flt.battery_fail;
    next_status.supply_status[fmirq_pkg::SUP_OVERVOLT_BIT] = flt.supply_overvolt && in_run_mode;
    next_status.supply_status[fmirq_pkg::SUP_UNDERVOLT_BIT] = flt.supply_undervolt && in_run_mode;
    next_status.supply_status[fmirq_pkg::SUP_REG_OVERTEMP_BIT] = flt.reg_prewarn && !in_low_power;
    next_status.lin_status[fmirq_pkg::LIN_RX_SHORT_BIT] = flt.rx_short;
    next_status.lin_status[fmirq_pkg::LIN_TX_DOMINANT_BIT] = next_tx_dominant_off;
    next_status.lin_status[fmirq_pkg::LIN_OVERTEMP_BIT] = flt.lin_overtemp;
    if (next_hs_thermal_off) begin
      next_status.high_side_status = fmirq_pkg::FLAGS_ALL;
    end else begin
      next_status.high_side_status[fmirq_pkg::HS_OPEN_LOAD_BIT] = flt.hs_open && in_run_mode;
      next_status.high_side_status[fmirq_pkg::HS_CURRENT_LIMIT_BIT] = flt.hs_limit && in_run_mode;
    end
    if (next_ls_thermal_off) begin
      next_status.low_side_status = fmirq_pkg::FLAGS_ALL;
    end else begin
      next_status.low_side_status[fmirq_pkg::LS1_OPEN_LOAD_BIT] = flt.ls1_open && in_run_mode;
      next_status.low_side_status[fmirq_pkg::LS2_OPEN_LOAD_BIT] = flt.ls2_open && in_run_mode;
      next_status.low_side_status[fmirq_pkg::LS1_CURRENT_LIMIT_BIT] = flt.ls1_limit && in_run_mode;
      next_status.low_side_status[fmirq_pkg::LS2_CURRENT_LIMIT_BIT] = flt.ls2_limit && in_run_mode;
    end
    next_status.watchdog_status[fmirq_pkg::WD_ERROR_BIT] = flt.wd_pin_floating;

    // Current limiting never switches a driver off; latches, LIN overtemp, RX short and low-power modes do.
    next_high_side_enable = !next_hs_thermal_off && !next_hs_hv_off;
    next_low_side_enable = !next_ls_thermal_off && !next_ls_hv_off && !in_low_power;
    next_lin_tx_enable = !next_tx_dominant_off && !flt.lin_overtemp && !flt.rx_short;
    next_regulator_enable = !next_reg_shut;

    next_host_reset_req = 1'b0;
    if (nreq_expired) begin
      next_host_reset_req = 1'b1;
    end
    if ((mode == fmirq_pkg::MODE_NORMAL) && (wd_expired || wd_clear_closed)) begin
      next_host_reset_req = 1'b1;
    end
    if (flt.reg_overtemp && !in_low_power && !reg_shut) begin
      next_host_reset_req = 1'b1;
    end

    next_go_sleep = 1'b0;
    if ((mode == fmirq_pkg::MODE_RESET) && flt.vdd_undervolt && !flt.supply_undervolt) begin
      next_go_sleep = 1'b1;
    end
    if (reg_shut && (mode == fmirq_pkg::MODE_RESET)) begin
      next_go_sleep = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      status <= '{default: fmirq_pkg::FLAGS_RESET};
      lin_tx_enable <= 1'b1;
      high_side_enable <= 1'b1;
      low_side_enable <= 1'b1;
      regulator_enable <= 1'b1;
      host_reset_req <= 1'b0;
      go_sleep <= 1'b0;
    end else begin
      status <= next_status;
      lin_tx_enable <= next_lin_tx_enable;
      high_side_enable <= next_high_side_enable;
      low_side_enable <= next_low_side_enable;
      regulator_enable <= next_regulator_enable;
      host_reset_req <= next_host_reset_req;
      go_sleep <= next_go_sleep;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  logic ev_hs;
  logic ev_ls;
  logic ev_tx;
  logic ev_supply;
  logic transmit_dominant_flag_prev;
  logic [3:0] next_interrupt_source;
  logic next_irq_b;

  // Events are rising edges of the synchronised faults and of the TX dominant latch, so a lingering
  // condition interrupts once rather than on every acknowledge.
  assign ev_hs = flt.hs_overtemp && !flt_prev.hs_overtemp && !irq_mask.hs;
  assign ev_ls = flt.ls_overtemp && !flt_prev.ls_overtemp && !irq_mask.ls;
  assign ev_tx = next_tx_dominant_off && !transmit_dominant_flag_prev && !irq_mask.tx_dominant;
  assign ev_supply = ((flt.supply_overvolt && !flt_prev.supply_overvolt)
                      || (flt.supply_undervolt && !flt_prev.supply_undervolt))
                     && !irq_mask.supply && in_run_mode;

  always_comb begin
    next_interrupt_source = interrupt_source;
    next_irq_b = irq_b;
    if (irq_ack) begin
      next_interrupt_source = fmirq_pkg::SRC_NONE;
      next_irq_b = 1'b1;
    end
    // A new event in the acknowledge cycle wins over the clear.
    if (irq_allowed && (ev_hs || ev_ls || ev_tx || ev_supply)) begin
      next_irq_b = 1'b0;
      if (ev_hs) begin
        next_interrupt_source = fmirq_pkg::SRC_HIGH_SIDE;
      end else if (ev_ls) begin
        next_interrupt_source = fmirq_pkg::SRC_LOW_SIDE;
      end else if (ev_tx) begin
        next_interrupt_source = fmirq_pkg::SRC_TX_DOMINANT;
      end else begin
        next_interrupt_source = fmirq_pkg::SRC_SUPPLY;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      flt_prev <= '0;
      transmit_dominant_flag_prev <= 1'b0;
      interrupt_source <= fmirq_pkg::SRC_NONE;
      irq_b <= 1'b1;
    end else begin
      flt_prev <= flt;
      transmit_dominant_flag_prev <= next_tx_dominant_off;
      interrupt_source <= next_interrupt_source;
      irq_b <= next_irq_b;
    end
  end

endmodule

/* File: fmirq_pkg.sv */
// Constants, modes and carriers for the fault monitor and interrupt block.
// Assumes a 10 MHz system clock and a device mode machine that reports its mode.
//
// How it works
// - Long TXD low disables LIN, sets bit 2.
// - HS overtemp: output off, all HS flags set.
// - HS stays off until clear and control write.
// - LS overtemp switches off both low sides.
// - LS thermal shutdown sets all LS flags.
// - LS stays off until clear and control write.
// - LS current limit keeps output, flags bit 0/2.
// - Normal Request timeout issues a host reset.
// - Watchdog expiry or early clear resets host.
// - Floating watchdog pin sets error bit 2.
// - Reset mode, VDD low, no VS low: sleep.
// - Interrupts only in Normal, Request, Stop.
// - Unmasked fault: IRQ low, load source code.
// - Regulator overtemp: shut down, reset, then sleep.
// - Regulator prewarning flag follows condition, bit 1.
// - LIN overtemp: driver off, flag bit 1.
// - High voltage shutdown only when enable bit set.
package fmirq_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TRANSMIT_DOMINANT_FLAG_TIME_MS = 1000;
  localparam int unsigned TRANSMIT_DOMINANT_FLAG_CYCLES = TRANSMIT_DOMINANT_FLAG_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned NREQ_TIME_MS = 150;
  localparam int unsigned NREQ_CYCLES = NREQ_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned SUP_BATTERY_FAIL_BIT = 0;
  localparam int unsigned SUP_REG_OVERTEMP_BIT = 1;
  localparam int unsigned SUP_UNDERVOLT_BIT = 2;
  localparam int unsigned SUP_OVERVOLT_BIT = 3;
  localparam int unsigned LIN_OVERTEMP_BIT = 1;
  localparam int unsigned LIN_TX_DOMINANT_BIT = 2;
  localparam int unsigned LIN_RX_SHORT_BIT = 3;
  localparam int unsigned HS_CURRENT_LIMIT_BIT = 0;
  localparam int unsigned HS_OPEN_LOAD_BIT = 1;
  localparam int unsigned LS1_CURRENT_LIMIT_BIT = 0;
  localparam int unsigned LS1_OPEN_LOAD_BIT = 1;
  localparam int unsigned LS2_CURRENT_LIMIT_BIT = 2;
  localparam int unsigned LS2_OPEN_LOAD_BIT = 3;
  localparam int unsigned WD_ERROR_BIT = 2;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [3:0] FLAGS_ALL = 4'hf;
  localparam logic [3:0] SRC_NONE = 4'h0;
  localparam logic [3:0] SRC_HIGH_SIDE = 4'h2;
  localparam logic [3:0] SRC_LOW_SIDE = 4'h3;
  localparam logic [3:0] SRC_TX_DOMINANT = 4'h4;
  localparam logic [3:0] SRC_SUPPLY = 4'h5;

  typedef enum logic [2:0] {
    MODE_RESET = 3'b000,
    MODE_NORMAL_REQUEST = 3'b001,
    MODE_NORMAL = 3'b010,
    MODE_STOP = 3'b011,
    MODE_SLEEP = 3'b100
  } fmirq_mode_e;

  typedef struct packed {
    logic wd_pin_floating;
    logic ls2_limit;
    logic ls1_limit;
    logic ls2_open;
    logic ls1_open;
    logic ls_overtemp;
    logic hs_limit;
    logic hs_open;
    logic hs_overtemp;
    logic lin_overtemp;
    logic rx_short;
    logic reg_overtemp;
    logic reg_prewarn;
    logic vdd_undervolt;
    logic battery_fail;
    logic supply_undervolt;
    logic supply_overvolt;
  } fmirq_fault_s;

  typedef struct packed {
    logic hs;
    logic ls;
    logic tx_dominant;
    logic supply;
  } fmirq_mask_s;

  typedef struct packed {
    logic [3:0] supply_status;
    logic [3:0] lin_status;
    logic [3:0] high_side_status;
    logic [3:0] low_side_status;
    logic [3:0] watchdog_status;
  } fmirq_status_s;

endpackage

/* File: fmirq_sync.sv */
// Two-stage synchroniser for a bundle of comparator levels.
// Assumes each bit is a slow level; only the second stage is read.
`timescale 1ns/1ps
module fmirq_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  generate
    if (WIDTH < 1 || fmirq_pkg::SYNC_STAGES != 2) begin : g_check
      $error("fmirq_sync needs WIDTH of at least 1.");
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_one <= '0;
      sync_out <= '0;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end

endmodule

/* File: fmirq_timer.sv */
// Run-length timer: pulses once when run has held for LIMIT cycles.
// Assumes run drops to restart; no pulse repeats while run stays high.
`timescale 1ns/1ps
module fmirq_timer #(
  parameter int unsigned LIMIT = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Control
  input wire logic run,
  output logic expired
);

  localparam int unsigned CW = $clog2(LIMIT + 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic next_expired;

  generate
    if (LIMIT < 2) begin : g_check
      $error("fmirq_timer needs LIMIT of at least 2.");
    end
  endgenerate

  always_comb begin
    next_count = count;
    next_expired = 1'b0;
    if (!run) begin
      next_count = '0;
    end else if (count < CW'(LIMIT)) begin
      next_count = count + 1'b1;
      next_expired = (count == CW'(LIMIT - 1));
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
      expired <= 1'b0;
    end else begin
      count <= next_count;
      expired <= next_expired;
    end
  end

endmodule

/* File: fmirq_monitor_assertions.sv */
// Concurrent checks on the ports of the fault monitor.
// Assumes the bench hands on the shortened timer counts through bind.
`timescale 1ns/1ps
module fmirq_monitor_assertions #(
  parameter int unsigned TRANSMIT_DOMINANT_FLAG_CYCLES = 20,
  parameter int unsigned NREQ_CYCLES = 20
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Inputs watched
  input wire fmirq_pkg::fmirq_mode_e mode,
  input wire logic txd,
  input wire fmirq_pkg::fmirq_fault_s fault_raw,
  input wire logic wd_expired,
  input wire logic wd_clear_closed,
  input wire logic high_side_control_write,
  input wire fmirq_pkg::fmirq_mask_s irq_mask,
  // Outputs watched
  input wire fmirq_pkg::fmirq_status_s status,
  input wire logic [3:0] interrupt_source,
  input wire logic irq_b,
  input wire logic lin_tx_enable,
  input wire logic high_side_enable,
  input wire logic low_side_enable,
  input wire logic host_reset_req
);
  // ----------------------------------------------------------------
  // Run-length counters
  // ----------------------------------------------------------------
  // Counters saturate so a long stall cannot wrap and fake a fresh start.
  logic [7:0] tx_cnt;
  logic [7:0] next_tx_cnt;
  logic [7:0] nreq_cnt;
  logic [7:0] next_nreq_cnt;
  logic tx_run;
  always_comb begin
    tx_run = (mode == fmirq_pkg::MODE_NORMAL || mode == fmirq_pkg::MODE_NORMAL_REQUEST) && !txd &&
      !fault_raw.lin_overtemp && !fault_raw.rx_short;
    next_tx_cnt = !tx_run ? 8'h0 : (tx_cnt == 8'hff) ? tx_cnt : tx_cnt + 8'h1;
    next_nreq_cnt = (mode != fmirq_pkg::MODE_NORMAL_REQUEST) ? 8'h0 : (nreq_cnt == 8'hff) ? nreq_cnt : nreq_cnt + 8'h1;
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_cnt <= 8'h0;
      nreq_cnt <= 8'h0;
    end else begin
      tx_cnt <= next_tx_cnt;
      nreq_cnt <= next_nreq_cnt;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_hs_hot;
    fault_raw.hs_overtemp [*4];
  endsequence
  sequence s_ls_hot;
    fault_raw.ls_overtemp [*4];
  endsequence
  a_hs_shut_down: assert property (s_hs_hot |=> !high_side_enable && status.high_side_status == 4'hf)
    else $error("high side left on during overtemp");
  a_hs_write_rearm: assert property ($rose(high_side_enable) |-> $past(high_side_control_write))
    else $error("high side came back without a control write");
  a_ls_both_off: assert property (s_ls_hot |=> !low_side_enable && status.low_side_status == 4'hf)
    else $error("low sides left on during overtemp");
  a_ls_limit_flag: assert property (fault_raw.ls2_limit [*4] |=> status.low_side_status[2])
    else $error("second low side limit flag missing");
  a_tx_dom_cut: assert property (tx_cnt > TRANSMIT_DOMINANT_FLAG_CYCLES + 6 |-> !lin_tx_enable && status.lin_status[2])
    else $error("transmitter not cut after long dominant");
  a_nreq_timeout: assert property (nreq_cnt == NREQ_CYCLES |-> ##[0:4] host_reset_req)
    else $error("no reset after request timeout");
  a_wd_host_reset: assert property (mode == fmirq_pkg::MODE_NORMAL && (wd_expired || wd_clear_closed)
    |-> ##[1:2] host_reset_req)
    else $error("no reset after watchdog event");
  a_irq_mode_gate: assert property ((mode == fmirq_pkg::MODE_SLEEP && irq_b) [*4] |=> irq_b)
    else $error("interrupt raised in sleep");
  a_irq_mask_hold: assert property ((irq_mask == 4'hf && irq_b) [*4] |=> irq_b)
    else $error("masked fault raised the interrupt");
  a_irq_src_code: assert property ($fell(irq_b) |-> interrupt_source inside {4'h2, 4'h3, 4'h4, 4'h5})
    else $error("interrupt with an unknown source code");
endmodule

/* File: fmirq_host_model.sv */
// Host that services the fault interrupt: waits, reads the source, acknowledges.
// Assumes the monitor clears its line on the edge after the acknowledge.
`timescale 1ns/1ps
module fmirq_host_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Interrupt side
  input wire logic irq_b,
  input wire logic [3:0] interrupt_source,
  input wire logic [7:0] ack_delay,
  output logic irq_ack,
  // What the host has read
  output logic [3:0] last_source,
  output logic [7:0] ack_count
);
  logic [7:0] wait_cnt;
  // The source is read only while the line is low, so a late host sees the latest code.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_ack <= 1'b0;
      wait_cnt <= 8'h0;
      last_source <= 4'h0;
      ack_count <= 8'h0;
    end else if (irq_ack) begin
      irq_ack <= 1'b0;
      wait_cnt <= 8'h0;
    end else if (!irq_b && wait_cnt >= ack_delay) begin
      irq_ack <= 1'b1;
      last_source <= interrupt_source;
      ack_count <= ack_count + 8'h1;
    end else if (!irq_b) begin
      wait_cnt <= wait_cnt + 8'h1;
    end
  end
endmodule

/* File: test_fmirq_monitor.sv */
// Self-checking bench for the fault monitor with a host model on the interrupt.
// Assumes shortened timer counts; the dominant and request timeout expectations are derived from them.
`timescale 1ns/1ps
module test_fmirq_monitor;
  localparam int unsigned TX_N = 20;
  localparam int unsigned NREQ_N = 20;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  fmirq_pkg::fmirq_mode_e mode = fmirq_pkg::MODE_NORMAL;
  logic txd = 1'b1;
  fmirq_pkg::fmirq_fault_s fault_raw = '0;
  logic wd_expired = 1'b0;
  logic wd_clear_closed = 1'b0;
  logic high_side_control_write = 1'b0;
  logic low_side_control_write = 1'b0;
  logic high_voltage_shutdown_enable = 1'b0;
  fmirq_pkg::fmirq_mask_s irq_mask = 4'h0;
  logic [7:0] ack_delay = 8'h2;
  logic irq_ack, irq_b, lin_tx_enable, high_side_enable, low_side_enable;
  logic regulator_enable, host_reset_req, go_sleep;
  fmirq_pkg::fmirq_status_s status;
  logic [3:0] interrupt_source, last_source;
  logic [7:0] ack_count, a0;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  int resets = 0;
  int r0;
  int fb[10] = '{2, 4, 1, 7, 6, 10, 9, 12, 13, 16};
  int sb[10] = '{16, 17, 18, 13, 15, 8, 9, 5, 7, 2};

  fmirq_monitor #(.TRANSMIT_DOMINANT_FLAG_CYCLES(TX_N), .NREQ_CYCLES(NREQ_N)) u_fmirq_monitor (.sys_clk, .rst_b, .mode, .txd,
    .fault_raw, .wd_expired, .wd_clear_closed, .high_side_control_write, .low_side_control_write,
    .high_voltage_shutdown_enable, .irq_mask, .irq_ack, .status, .interrupt_source, .irq_b, .lin_tx_enable,
    .high_side_enable, .low_side_enable, .regulator_enable, .host_reset_req, .go_sleep);
  fmirq_host_model u_fmirq_host_model (.sys_clk, .rst_b, .irq_b, .interrupt_source, .ack_delay, .irq_ack,
    .last_source, .ack_count);

  always #50 sys_clk = ~sys_clk;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // The ceiling is several times the expected run, so only a real hang trips it.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (host_reset_req === 1'b1) resets <= resets + 1;
    if (cycles == 4000) begin
      fails = fails + 1;
      conclude();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic strobe(input logic [3:0] s);
    {high_side_control_write, low_side_control_write, wd_expired, wd_clear_closed} <= s;
    cyc(1);
    {high_side_control_write, low_side_control_write, wd_expired, wd_clear_closed} <= 4'h0;
  endtask
  task automatic thermal(input bit ls);
    logic [3:0] w;
    w = ls ? 4'h4 : 4'h8;
    if (ls) fault_raw.ls_overtemp <= 1'b1;
    else fault_raw.hs_overtemp <= 1'b1;
    cyc(8);
    check("thermal off", ls ? {low_side_enable, status.low_side_status}
      : {high_side_enable, status.high_side_status}, 5'h0f);
    check("thermal src", last_source, ls ? fmirq_pkg::SRC_LOW_SIDE : fmirq_pkg::SRC_HIGH_SIDE);
    strobe(w);
    cyc(1);
    check("hot write", ls ? low_side_enable : high_side_enable, 1'b0);
    fault_raw <= '0;
    cyc(5);
    check("cool no write", ls ? low_side_enable : high_side_enable, 1'b0);
    strobe(w);
    cyc(1);
    check("rearm", ls ? low_side_enable : high_side_enable, 1'b1);
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    cyc(6);
    rst_b <= 1'b1;
    cyc(3);
    check("reset status", status, 20'h0);
    check("reset lines", {irq_b, lin_tx_enable, high_side_enable, low_side_enable, regulator_enable}, 5'h1f);
    thermal(1'b0);
    thermal(1'b1);
    a0 = ack_count;
    irq_mask <= 4'hf;
    fault_raw.hs_overtemp <= 1'b1;
    cyc(8);
    check("masked", {irq_b, interrupt_source, ack_count}, {1'b1, 4'h0, a0});
    mode <= fmirq_pkg::MODE_SLEEP;
    irq_mask <= 4'h0;
    fault_raw.ls_overtemp <= 1'b1;
    cyc(8);
    check("sleep quiet", {irq_b, ack_count}, {1'b1, a0});
    fault_raw <= '0;
    mode <= fmirq_pkg::MODE_NORMAL;
    cyc(5);
    strobe(4'hc);
    cyc(1);
    fault_raw.ls1_limit <= 1'b1;
    fault_raw.ls2_limit <= 1'b1;
    cyc(5);
    check("limit", {low_side_enable, status.low_side_status}, 5'h15);
    fault_raw <= '0;
    ack_delay <= 8'h10;
    txd <= 1'b0;
    cyc(TX_N + 26);
    check("tx dominant", {lin_tx_enable, status.lin_status[2], last_source}, 6'h14);
    txd <= 1'b1;
    ack_delay <= 8'h2;
    cyc(3);
    check("tx release", {lin_tx_enable, status.lin_status[2]}, 2'h2);
    for (int e = 0; e < 2; e++) begin
      high_voltage_shutdown_enable <= e[0];
      fault_raw.supply_overvolt <= 1'b1;
      cyc(8);
      check("hv shutdown", {high_side_enable, low_side_enable, status.supply_status[3], last_source},
        {{2{~e[0]}}, 5'h15});
      fault_raw.supply_overvolt <= 1'b0;
      cyc(5);
      strobe(4'hc);
      cyc(1);
      check("hv rearm", {high_side_enable, low_side_enable}, 2'h3);
    end
    for (int i = 0; i < 10; i++) begin
      fault_raw <= fmirq_pkg::fmirq_fault_s'(17'h1 << fb[i]);
      cyc(5);
      check("flag", status, 20'h1 << sb[i]);
      check("lin on", lin_tx_enable, (i == 3 || i == 4) ? 1'b0 : 1'b1);
      fault_raw <= '0;
      cyc(5);
      check("flag gone", status, 20'h0);
    end
    for (int i = 0; i < 2; i++) begin
      r0 = resets;
      strobe(i ? 4'h1 : 4'h2);
      cyc(3);
      check("wd reset", resets - r0, 20'h1);
    end
    r0 = resets;
    mode <= fmirq_pkg::MODE_NORMAL_REQUEST;
    cyc(NREQ_N - 3);
    check("nreq early", resets - r0, 20'h0);
    cyc(8);
    check("nreq timeout", resets - r0, 20'h1);
    mode <= fmirq_pkg::MODE_NORMAL;
    cyc(2);
    r0 = resets;
    fault_raw.reg_overtemp <= 1'b1;
    cyc(6);
    check("reg shut", {regulator_enable, 8'(resets - r0)}, 9'h001);
    mode <= fmirq_pkg::MODE_RESET;
    cyc(3);
    check("reg sleep", go_sleep, 1'b1);
    mode <= fmirq_pkg::MODE_SLEEP;
    fault_raw <= '0;
    cyc(5);
    mode <= fmirq_pkg::MODE_RESET;
    fault_raw.vdd_undervolt <= 1'b1;
    cyc(5);
    check("vdd sleep", {regulator_enable, go_sleep}, 2'h3);
    fault_raw.supply_undervolt <= 1'b1;
    cyc(5);
    check("vs low stay", go_sleep, 1'b0);
    mode <= fmirq_pkg::MODE_STOP;
    fault_raw.hs_overtemp <= 1'b1;
    cyc(8);
    check("stop irq", {low_side_enable, last_source}, 5'h02);
    conclude();
  end
endmodule

bind fmirq_monitor fmirq_monitor_assertions #(.TRANSMIT_DOMINANT_FLAG_CYCLES(TRANSMIT_DOMINANT_FLAG_CYCLES), .NREQ_CYCLES(NREQ_CYCLES)) u_chk (
  .sys_clk, .rst_b, .mode, .txd, .fault_raw, .wd_expired, .wd_clear_closed, .high_side_control_write,
  .irq_mask, .status, .interrupt_source, .irq_b, .lin_tx_enable, .high_side_enable, .low_side_enable,
  .host_reset_req);
